// file: include/fhc_pkg.sv
// Constants and types for the flash lock and status-pin host controller.
// Assumes a 20 MHz aclk and a flash on an asynchronous parallel bus.
`default_nettype none
package fhc_pkg;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLK_NS   = 50;  // Clock period in ns.
    localparam int T_WP_NS  = 70;  // Least write-enable low time.
    localparam int T_WPH_NS = 30;  // Least write-enable high time.
    localparam int T_ACC_NS = 150; // Read access time.
    localparam int T_RP_NS  = 100; // Least reset pin low time.

    // Rounds a least time up to whole cycles.
    function automatic int cyc_up(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    localparam logic [7:0] WP_CYC  = 8'(cyc_up(T_WP_NS));
    localparam logic [7:0] WPH_CYC = 8'(cyc_up(T_WPH_NS));
    localparam logic [7:0] ACC_CYC = 8'(cyc_up(T_ACC_NS));
    localparam logic [7:0] RP_CYC  = 8'(cyc_up(T_RP_NS));

    // ****************************************************************
    // Register map and fields.
    // ****************************************************************
    localparam logic [7:0] OFS_CMD  = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam int ST_BUSY   = 0;
    localparam int ST_REFUSE = 1;
    localparam int ST_PULSE  = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Device status byte bit positions.
    localparam int SRB_READY = 7;
    localparam int SRB_EERR  = 5;
    localparam int SRB_PERR  = 4;
    localparam int SRB_VERR  = 3;
    localparam int SRB_SUSP  = 2;

    // Device command bytes.
    localparam logic [7:0] CMD_RD_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLR_STATUS = 8'hc5;
    localparam logic [7:0] CMD_CONFIG     = 8'hc1;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'hc2;
    localparam logic [7:0] CMD_LSET_CONF  = 8'hc3;
    localparam logic [7:0] CMD_LCLR_CONF  = 8'hc4;

    // Status pin mode; zero is the ready/busy level mode.
    localparam logic [1:0] MODE_LEVEL = 2'h0;

    // Orders that software gives.
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_CFG  = 3'h1,
        OP_LSET = 3'h2,
        OP_LCLR = 3'h3,
        OP_CLRS = 3'h4,
        OP_RDS  = 3'h5,
        OP_RST  = 3'h6
    } fhc_op_t;

    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_RSC  = 8'h02,
        S_CHK  = 8'h04,
        S_WR1  = 8'h08,
        S_WR2  = 8'h10,
        S_POLL = 8'h20,
        S_CLR  = 8'h40,
        S_RST  = 8'h80
    } fhc_st_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dq_o;
        logic        dq_oe;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        rp_n;
    } fhc_pin_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } fhc_axi_t;

endpackage
`default_nettype wire

// file: logic/fhc_ctrl.sv
// Host controller that drives a parallel flash to set the status pin
// mode, set one block lock, clear all locks and read status.
// Assumes software on AXI4-Lite and a flash that needs no clock.
// Function
// - Config command then code next write.
// - Configure only when not busy, not suspended.
// - Set-lock setup then confirm within block.
// - After set-lock check program error, clear.
// - Clear-lock setup then confirm, consecutive writes.
// - After clear-lock check erase error, clear.
// - Aborted clear-lock needs repeating; the code does not repeat it, it only sets locks_unk.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fhc_ctrl
    import fhc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [23:0]      fl_addr,
    output logic [15:0]      fl_dq_o,
    input  wire logic [15:0] fl_dq_i,
    output logic             fl_dq_oe,
    output logic             fl_ce_n,
    output logic             fl_oe_n,
    output logic             fl_we_n,
    output logic             reset_powerdown_pin_n,
    input  wire logic        status_output_pin
);

    // ****************************************************************
    // State.
    // ****************************************************************

    // All state of the controller in one record.
    typedef struct packed {
        fhc_st_t     st;         // Sequencer state.
        logic [7:0]  cnt;        // Cycle count inside a bus cycle.
        fhc_op_t     op;         // Order being carried out.
        logic [7:0]  code;       // Configuration code from software.
        logic [23:0] addr;       // Block address from software.
        logic [7:0]  srv;        // Last status byte read.
        logic [1:0]  mode;       // Status pin mode last accepted.
        logic        busy;       // An order is under way.
        logic        refused;    // Last order refused as not ready, suspended or unknown.
        logic        pulse_seen; // A completion pulse was caught.
        logic        locks_unk;  // Lock bits may be undefined.
        logic [2:0]  sync;       // Status pin synchroniser.
        logic        sts_lvl;    // Filtered status pin level.
        fhc_pin_t    pin;        // Flash pin drivers.
        fhc_axi_t    axi;        // Bus answer signals.
    } fhc_state_t;

    fhc_state_t r_reg;  // Registered state.
    fhc_state_t r_next; // Next state.
    logic       in_wr;  // A write cycle is on the flash bus.
    logic       in_rd;  // A read cycle is on the flash bus.
    logic       wr_end; // Last cycle of a write.
    logic       rd_end; // Last cycle of a read.
    logic [7:0] wbyte;  // Byte driven in a write cycle.

    // ****************************************************************
    // Bus cycle decode.
    // ****************************************************************

    // Classifies the state and picks the byte for each write.
    always_comb
    begin
        in_wr  = (r_reg.st == S_RSC) || (r_reg.st == S_WR1)
              || (r_reg.st == S_WR2) || (r_reg.st == S_CLR);
        in_rd  = (r_reg.st == S_CHK) || (r_reg.st == S_POLL);
        wr_end = r_reg.cnt == WP_CYC + WPH_CYC;
        rd_end = r_reg.cnt == ACC_CYC + 8'h01;
        wbyte  = CMD_RD_STATUS;
        if (r_reg.st == S_CLR)
        begin
            wbyte = CMD_CLR_STATUS;
        end
        else if (r_reg.st == S_WR1)
        begin
            // Setup byte of each two-cycle order.
            wbyte = (r_reg.op == OP_CFG) ? CMD_CONFIG : CMD_LOCK_SETUP;
        end
        else if (r_reg.st == S_WR2)
        begin
            // Second byte follows in the very next write.
            if (r_reg.op == OP_CFG)
            begin
                wbyte = r_reg.code;
            end
            else if (r_reg.op == OP_LSET)
            begin
                wbyte = CMD_LSET_CONF;
            end
            else
            begin
                wbyte = CMD_LCLR_CONF;
            end
        end
    end

    // ****************************************************************
    // Next state.
    // ****************************************************************

    // Bus slave, pin filter and the flash sequencer.
    always_comb
    begin
        r_next = r_reg;

        // The first stage feeds only the second.
        r_next.sync = {r_reg.sync[1:0], status_output_pin};

        // Write channel: address and data taken together.
        r_next.axi.awready = 1'b0;
        r_next.axi.wready  = 1'b0;
        if (r_reg.axi.bvalid && s_axi_bready)
        begin
            r_next.axi.bvalid = 1'b0;
        end
        if (!r_reg.axi.bvalid && !r_reg.axi.awready
            && s_axi_awvalid && s_axi_wvalid)
        begin
            r_next.axi.awready = 1'b1;
            r_next.axi.wready  = 1'b1;
        end
        if (r_reg.axi.awready)
        begin
            r_next.axi.bvalid = 1'b1;
            r_next.axi.bresp  = RESP_OKAY;
            case (s_axi_awaddr)
                OFS_CMD:
                begin
                    // A new order is ignored while one runs.
                    if (!r_reg.busy && s_axi_wstrb[0])
                    begin
                        r_next.op      = fhc_op_t'(s_axi_wdata[2:0]);
                        r_next.busy    = s_axi_wdata[2:0] != OP_NONE;
                        r_next.refused = 1'b0;
                        if (s_axi_wstrb[1])
                        begin
                            r_next.code = s_axi_wdata[15:8];
                        end
                    end
                end
                OFS_ADDR:
                begin
                    // Each byte lane updates only its own byte.
                    for (int i = 0; i < 3; i++)
                    begin
                        if (s_axi_wstrb[i])
                        begin
                            r_next.addr[8*i +: 8] = s_axi_wdata[8*i +: 8];
                        end
                    end
                end
                OFS_STAT:
                begin
                    // Writing one clears the caught pulse.
                    if (s_axi_wstrb[0] && s_axi_wdata[ST_PULSE])
                    begin
                        r_next.pulse_seen = 1'b0;
                    end
                end
                default:
                begin
                    r_next.axi.bresp = RESP_SLVERR;
                end
            endcase
        end

        // A level counts once second and third stage agree.
        if (r_reg.sync[1] == r_reg.sync[2])
        begin
            r_next.sts_lvl = r_reg.sync[2];
        end
        // A falling edge in a pulse mode is a completion event; it
        // comes after the clear above so a coinciding event stays.
        if (r_reg.mode != MODE_LEVEL && r_reg.sts_lvl && !r_next.sts_lvl)
        begin
            r_next.pulse_seen = 1'b1;
        end

        // Read channel.
        r_next.axi.arready = 1'b0;
        if (r_reg.axi.rvalid && s_axi_rready)
        begin
            r_next.axi.rvalid = 1'b0;
        end
        if (!r_reg.axi.rvalid && !r_reg.axi.arready && s_axi_arvalid)
        begin
            r_next.axi.arready = 1'b1;
        end
        if (r_reg.axi.arready)
        begin
            r_next.axi.rvalid = 1'b1;
            r_next.axi.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                OFS_CMD:  r_next.axi.rdata = {16'h0000, r_reg.code, 5'h00, r_reg.op};
                OFS_ADDR: r_next.axi.rdata = {8'h00, r_reg.addr};
                OFS_STAT: r_next.axi.rdata = {14'h0000, r_reg.mode, r_reg.srv, 3'h0,
                                              r_reg.locks_unk, r_reg.pulse_seen,
                                              r_reg.sts_lvl, r_reg.refused, r_reg.busy};
                default:
                begin
                    r_next.axi.rdata = 32'h0000_0000;
                    r_next.axi.rresp = RESP_SLVERR;
                end
            endcase
        end

        // Flash pins follow the current bus cycle.
        r_next.pin.addr  = r_reg.addr;
        r_next.pin.dq_o  = {8'h00, wbyte};
        r_next.pin.dq_oe = in_wr;
        r_next.pin.ce_n  = !(in_wr || in_rd);
        r_next.pin.we_n  = !(in_wr && r_reg.cnt >= 8'h01 && r_reg.cnt <= WP_CYC);
        r_next.pin.oe_n  = !(in_rd && r_reg.cnt < ACC_CYC);
        r_next.pin.rp_n  = r_reg.st != S_RST;
        r_next.cnt       = r_reg.cnt + 8'h01;

        unique case (r_reg.st)
            S_IDLE:
            begin
                r_next.cnt = 8'h00;
                if (r_reg.busy)
                begin
                    if (r_reg.op == OP_RST)
                    begin
                        r_next.st = S_RST;
                    end
                    else if (r_reg.op > OP_RST)
                    begin
                        // An unknown order ends at once as refused.
                        r_next.busy    = 1'b0;
                        r_next.refused = 1'b1;
                    end
                    else
                    begin
                        r_next.st = S_RSC;
                    end
                end
            end
            S_RSC:
            begin
                // Puts the device in status read mode first.
                if (wr_end)
                begin
                    r_next.st  = S_CHK;
                    r_next.cnt = 8'h00;
                end
            end
            S_CHK:
            begin
                if (r_reg.cnt == ACC_CYC)
                begin
                    r_next.srv = fl_dq_i[7:0];
                end
                if (rd_end)
                begin
                    r_next.cnt = 8'h00;
                    if (r_reg.op == OP_RDS)
                    begin
                        r_next.st   = S_IDLE;
                        r_next.busy = 1'b0;
                    end
                    else if (r_reg.op == OP_CLRS)
                    begin
                        r_next.st = S_CLR;
                    end
                    else if (!r_reg.srv[SRB_READY] || r_reg.srv[SRB_SUSP])
                    begin
                        // Busy or suspended: never start these orders.
                        r_next.st      = S_IDLE;
                        r_next.busy    = 1'b0;
                        r_next.refused = 1'b1;
                    end
                    else
                    begin
                        r_next.st = S_WR1;
                    end
                end
            end
            S_WR1:
            begin
                if (wr_end)
                begin
                    r_next.st  = S_WR2;
                    r_next.cnt = 8'h00;
                end
            end
            S_WR2:
            begin
                if (wr_end)
                begin
                    r_next.cnt = 8'h00;
                    if (r_reg.op == OP_CFG)
                    begin
                        // Reserved bits set make a bad code, which the
                        // device flags, so the mode is not taken then.
                        if (r_reg.code[7:2] == 6'h00)
                        begin
                            r_next.mode = r_reg.code[1:0];
                        end
                        r_next.st = S_RSC;
                        r_next.op = OP_RDS;
                    end
                    else
                    begin
                        // Device now answers every read with status.
                        r_next.st = S_POLL;
                    end
                end
            end
            S_POLL:
            begin
                if (r_reg.cnt == ACC_CYC)
                begin
                    r_next.srv = fl_dq_i[7:0];
                end
                if (rd_end)
                begin
                    r_next.cnt = 8'h00;
                    // Repeat reads until the ready bit rises.
                    if (r_reg.srv[SRB_READY])
                    begin
                        if (r_reg.op == OP_LCLR)
                        begin
                            // Low voltage leaves lock bits unknown.
                            r_next.locks_unk = r_reg.srv[SRB_VERR]
                                            || r_reg.srv[SRB_EERR];
                        end
                        if (r_reg.srv[SRB_EERR] || r_reg.srv[SRB_PERR]
                            || r_reg.srv[SRB_VERR])
                        begin
                            r_next.st = S_CLR;
                        end
                        else
                        begin
                            r_next.st   = S_IDLE;
                            r_next.busy = 1'b0;
                        end
                    end
                end
            end
            S_CLR:
            begin
                // Clears the status byte; the last value read stays.
                if (wr_end)
                begin
                    r_next.st   = S_IDLE;
                    r_next.busy = 1'b0;
                    r_next.cnt  = 8'h00;
                end
            end
            S_RST:
            begin
                // Device reset returns the pin to level mode.
                if (r_reg.cnt == RP_CYC)
                begin
                    r_next.st   = S_IDLE;
                    r_next.busy = 1'b0;
                    r_next.mode = MODE_LEVEL;
                    r_next.cnt  = 8'h00;
                end
            end
        endcase
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************

    // Registers the state; reset puts pins idle and the mode at level.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_reg          <= '0;
            r_reg.st       <= S_IDLE;
            r_reg.op       <= OP_NONE;
            r_reg.mode     <= MODE_LEVEL;
            r_reg.sync     <= 3'h7;
            r_reg.sts_lvl  <= 1'b1;
            r_reg.pin.ce_n <= 1'b1;
            r_reg.pin.oe_n <= 1'b1;
            r_reg.pin.we_n <= 1'b1;
            r_reg.pin.rp_n <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign s_axi_awready         = r_reg.axi.awready;
    assign s_axi_wready          = r_reg.axi.wready;
    assign s_axi_bvalid          = r_reg.axi.bvalid;
    assign s_axi_bresp           = r_reg.axi.bresp;
    assign s_axi_arready         = r_reg.axi.arready;
    assign s_axi_rvalid          = r_reg.axi.rvalid;
    assign s_axi_rresp           = r_reg.axi.rresp;
    assign s_axi_rdata           = r_reg.axi.rdata;
    assign fl_addr               = r_reg.pin.addr;
    assign fl_dq_o               = r_reg.pin.dq_o;
    assign fl_dq_oe              = r_reg.pin.dq_oe;
    assign fl_ce_n               = r_reg.pin.ce_n;
    assign fl_oe_n               = r_reg.pin.oe_n;
    assign fl_we_n               = r_reg.pin.we_n;
    assign reset_powerdown_pin_n = r_reg.pin.rp_n;

endmodule // fhc_ctrl

`default_nettype wire

// file: verification/fhc_ctrl_asserts.sv
// Checker for the flash host controller ports.
// Assumes it is bound into fhc_ctrl.
`timescale 1ns/1ps
`default_nettype none
module fhc_ctrl_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [15:0] fl_dq_o,
    input wire logic        fl_dq_oe,
    input wire logic        fl_ce_n,
    input wire logic        fl_oe_n,
    input wire logic        fl_we_n,
    input wire logic        reset_powerdown_pin_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A write strobe needs the chip selected and the data driven.
    a_we_qualified: assert property (!fl_we_n |-> !fl_ce_n && fl_dq_oe && fl_oe_n)
        else $error("write strobe without select or data");
    // The write strobe stays low exactly two cycles.
    a_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n[*2] ##1 fl_we_n)
        else $error("write strobe width wrong");
    // Status reads are single reads of three cycles with data released.
    a_oe_width: assert property ($fell(fl_oe_n) |-> (!fl_oe_n && !fl_dq_oe)[*3] ##1 fl_oe_n)
        else $error("read strobe width wrong");
    a_high_byte: assert property (fl_dq_oe |-> fl_dq_o[15:8] == 8'h00)
        else $error("upper data byte driven");
    a_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
        else $error("address and data ready split");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
    a_rp_width: assert property ($fell(reset_powerdown_pin_n) |-> !reset_powerdown_pin_n[*2])
        else $error("device reset pulse short");
    c_write: cover property ($fell(fl_we_n));
    c_read: cover property ($fell(fl_oe_n));
    c_rst: cover property ($fell(reset_powerdown_pin_n));
endmodule // fhc_ctrl_asserts
bind fhc_ctrl fhc_ctrl_asserts fhc_ctrl_asserts_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .fl_dq_o, .fl_dq_oe, .fl_ce_n,
    .fl_oe_n, .fl_we_n, .reset_powerdown_pin_n);
`default_nettype wire

// file: verification/fhc_flash_model.sv
// Behavioural flash device: status byte, pin mode and lock commands.
// Assumes commands are latched on the rising write strobe.
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_model
    import fhc_pkg::*;
#(
    parameter int BUSY_NS = 2000 // Lock algorithm run time.
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rp_n,
    input  wire logic [15:0] dq_o,
    input  wire logic        program_enable_voltage_ok,
    output logic [15:0]      dq_i,
    output logic             sts
);
    logic [7:0] sr   = 8'h80; // Status byte.
    logic [7:0] prev = 8'hff; // Last first-cycle command.
    logic [1:0] mode = 2'h0;  // Status pin mode.
    logic [7:0] lock = 8'h00; // A few block lock bits.
    logic       busy = 1'b0;  // Lock algorithm running.
    logic       pls  = 1'b1;  // Completion pulse.
    logic [15:0] last = 16'h0000;
    // Released data lines show the inverse of the last driven value.
    always @(negedge oe_n) last = {8'h00, sr};
    assign dq_i = (!ce_n && !oe_n) ? {8'h00, sr} : ~last;
    assign sts  = (mode == 2'h0) ? !busy : pls;
    // Runs a lock algorithm; ready bit low meanwhile.
    task automatic run(input logic clr);
        busy = 1'b1;
        sr[7] = 1'b0;
        #(BUSY_NS);
        if (clr) lock = 8'h00;
        busy = 1'b0;
        sr[7] = 1'b1;
        if (mode != 2'h0) begin pls = 1'b0; #250; pls = 1'b1; end
    endtask
    // Decodes each write cycle.
    always @(posedge we_n)
    begin
        if (!ce_n && rp_n && !busy)
        begin
            if (prev == CMD_CONFIG)
            begin
                if (dq_o[7:2] == 6'h00) mode = dq_o[1:0];
                else sr[5:4] = 2'b11;
                prev = 8'hff;
            end
            else if (prev == CMD_LOCK_SETUP)
            begin
                if (dq_o[7:0] == CMD_LCLR_CONF && !program_enable_voltage_ok) sr = sr | 8'h28;
                else if (dq_o[7:0] == CMD_LSET_CONF) begin lock[0] = 1'b1; fork run(1'b0); join_none end
                else if (dq_o[7:0] == CMD_LCLR_CONF) fork run(1'b1); join_none
                else sr[5:4] = 2'b11;
                prev = 8'hff;
            end
            else
            begin
                if (dq_o[7:0] == CMD_CLR_STATUS) sr[5:1] = 5'h00;
                prev = dq_o[7:0];
            end
        end
    end
    // Reset pin restores defaults.
    always @(negedge rp_n)
    begin
        mode = 2'h0;
        sr   = 8'h80;
        prev = 8'hff;
    end
endmodule // fhc_flash_model
`default_nettype wire

// file: verification/tb.sv
// Testbench for fhc_ctrl with a behavioural flash.
// Assumes the controller answers on AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tb
    import fhc_pkg::*;
;
    logic aclk = 0, aresetn = 0, program_enable_voltage_ok = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, bvalid, awready, wready;
    logic arvalid = 0, rready = 0, rvalid, arready;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, st;
    logic [1:0]  bresp, rresp, r;
    logic [23:0] fl_addr, a;
    logic [15:0] dq_o, dq_i;
    logic dq_oe, ce_n, oe_n, we_n, rp_n, sts;
    int error_cnt = 0, checks = 0, exp_mode = 0, seed = 32'hff42;
    always #25 aclk = ~aclk;
    fhc_ctrl fhc_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fl_addr(fl_addr),
        .fl_dq_o(dq_o), .fl_dq_i(dq_i), .fl_dq_oe(dq_oe), .fl_ce_n(ce_n), .fl_oe_n(oe_n),
        .fl_we_n(we_n), .reset_powerdown_pin_n(rp_n), .status_output_pin(sts));
    fhc_flash_model fhc_flash_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n),
        .dq_o(dq_o), .program_enable_voltage_ok(program_enable_voltage_ok), .dq_i(dq_i), .sts(sts));
    // Compares one value and counts it.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin error_cnt++; $display("[FAIL] %s expected %h seen %h", n, e, g); end
    endtask
    // One AXI write; address and data released as each is taken.
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
        logic aw = 1, w = 1;
        @(posedge aclk); awaddr <= ad; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (aw || w)
        begin
            @(posedge aclk);
            if (awready) begin awvalid <= 0; aw = 0; end
            if (wready) begin wvalid <= 0; w = 0; end
        end
        while (!bvalid) @(posedge aclk);
        rs = bresp;
        bready <= 0;
    endtask
    // One AXI read.
    task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk); araddr <= ad; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        while (!rvalid) @(posedge aclk);
        d = rdata; rs = rresp;
        rready <= 0;
    endtask
    // Issues an order, waits until idle, returns the status word.
    task automatic op(input logic [2:0] o, input logic [7:0] code);
        wr(OFS_CMD, {16'h0, code, 5'h0, o}, r);
        do rd(OFS_STAT, st, r); while (st[ST_BUSY] === 1'b1);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin #3_000_000; error_cnt++; results; end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd(OFS_STAT, st, r);
        chk("mode_rst", 0, st[17:16]);
        for (int c = 1; c < 5; c++)
        begin
            exp_mode = c % 4;
            op(3'h1, 8'(exp_mode));
            chk("mode", exp_mode, st[17:16]);
            chk("cfg_err", 0, st[13:12]);
        end
        op(3'h1, 8'h04);
        chk("bad_mode", exp_mode, st[17:16]);
        chk("bad_err", 3, st[13:12]);
        op(3'h4, 8'h00);
        a = 24'($random(seed));
        wr(OFS_ADDR, {8'h0, a}, r);
        op(3'h2, 8'h00);
        chk("lset_sr", 8'h80, st[15:8] & 8'hb8);
        chk("addr", a, fl_addr);
        op(3'h1, 8'h03);
        program_enable_voltage_ok <= 0;
        op(3'h3, 8'h00);
        chk("lclr_sr", 8'ha8, st[15:8] & 8'hb8);
        chk("unknown", 1, st[4]);
        program_enable_voltage_ok <= 1;
        op(3'h3, 8'h00);
        chk("lclr_ok", 8'h80, st[15:8] & 8'hb8);
        op(3'h6, 8'h00);
        chk("mode_rp", 0, st[17:16]);
        chk("pulse", 1, st[3]);
        op(3'h7, 8'h00);
        chk("refused", 1, st[ST_REFUSE]);
        wr(8'h1c, 32'h1, r);
        chk("wr_unmap", RESP_SLVERR, r);
        rd(8'h1c, st, r);
        chk("rd_unmap", RESP_SLVERR, r);
        results;
    end
endmodule // tb
`default_nettype wire
